// ==== include/eaps_pkg.sv ====
package eaps_pkg;

	// Clock and derived rates
	localparam int     CLK_HZ          = 250_000_000;
	localparam int     ACC_SAMPLE_CYC  = 4;
	localparam int     PERIOD_TICK_CYC = 8;
	localparam longint PULSE_MAX_HZ    = 23_000;
	localparam longint ACT_FULL_SCALE  = 64'h0000_0000_007F_FFFF;
	// Least raw pulse threshold so full scale stays at or below the pulse ceiling
	localparam longint PULSE_THRESHOLD_DEF =
		(ACT_FULL_SCALE * longint'(CLK_HZ / ACC_SAMPLE_CYC) + PULSE_MAX_HZ - 1) / PULSE_MAX_HZ;
	localparam int     PULSE_WIDTH_NS  = 1000;
	localparam int     PULSE_WIDTH_CYC = (PULSE_WIDTH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// Widths
	localparam int PWR_W  = 24;
	localparam int TOT_W  = 24;
	localparam int DIV_W  = 8;
	localparam int GAIN_W = 12;
	localparam int FRAC_W = 12;
	localparam int CFR_W  = 12;
	localparam int HALF_W = 16;
	localparam int PER_W  = 16;
	localparam int LOW_W  = 34;
	localparam int PG_W   = 26;
	localparam int PACC_W = 40;
	localparam int CRD_W  = CFR_W + 2;
	localparam int WCNT_W = 10;
	localparam int IDX_W  = 6;

	// Reset values
	localparam logic [DIV_W-1:0]  RST_DIV    = 8'h00;
	localparam logic [GAIN_W-1:0] RST_GAIN   = 12'h000;
	localparam logic [CFR_W-1:0]  RST_PULSE_NUM = 12'h03F;
	localparam logic [CFR_W-1:0]  RST_PULSE_DEN = 12'h03F;
	localparam logic [HALF_W-1:0] RST_HALF   = 16'h0001;

	// Register byte offsets
	localparam logic [7:0] OFS_APP_DIV   = 8'h00;
	localparam logic [7:0] OFS_ACT_DIV   = 8'h04;
	localparam logic [7:0] OFS_ACT_GAIN  = 8'h08;
	localparam logic [7:0] OFS_PULSE_NUM = 8'h0C;
	localparam logic [7:0] OFS_PULSE_DEN = 8'h10;
	localparam logic [7:0] OFS_HALF_SET  = 8'h14;
	localparam logic [7:0] OFS_APP_TOTAL = 8'h18;
	localparam logic [7:0] OFS_LINE_APP  = 8'h1C;
	localparam logic [7:0] OFS_ACT_TOTAL = 8'h20;
	localparam logic [7:0] OFS_LINE_ACT  = 8'h24;
	localparam logic [7:0] OFS_PERIOD    = 8'h28;

	// AHB encodings
	localparam logic [2:0] HSIZE_WORD = 3'b010;

	// Result of one divided accumulation step
	typedef struct packed {
		logic signed [LOW_W-1:0] low;
		logic signed [1:0]       step;
	} eaps_div_t;

	// State of the pulse scaler
	typedef struct packed {
		logic [CRD_W-1:0]  credit;
		logic [WCNT_W-1:0] wcnt;
		logic              pulse;
	} eaps_pulse_st_t;

	// State of the accumulation top
	typedef struct packed {
		logic [2:0]               tick_cnt;
		logic [DIV_W-1:0]         app_div;
		logic [DIV_W-1:0]         act_div;
		logic [GAIN_W-1:0]        act_gain;
		logic [CFR_W-1:0]         pulse_num;
		logic [CFR_W-1:0]         pulse_den;
		logic [HALF_W-1:0]        half_set;
		logic [HALF_W-1:0]        half_cnt;
		logic signed [LOW_W-1:0]  app_low;
		logic signed [LOW_W-1:0]  act_low;
		logic [TOT_W-1:0]         app_total;
		logic [TOT_W-1:0]         act_total;
		logic [TOT_W-1:0]         line_app_run;
		logic [TOT_W-1:0]         line_act_run;
		logic [TOT_W-1:0]         line_app;
		logic [TOT_W-1:0]         line_act;
		logic [PER_W-1:0]         period_cnt;
		logic [PER_W-1:0]         period;
		logic                     zx_phase;
		logic signed [PACC_W-1:0] pacc;
		logic                     raw_pulse;
		logic                     dp_valid;
		logic                     dp_write;
		logic [IDX_W-1:0]         dp_idx;
		logic [31:0]              hrdata;
	} eaps_top_st_t;

endpackage

// ==== hdl/eaps_pulse.sv ====
`timescale 1ns/1ps
module eaps_pulse #(
	parameter int WIDTH_CYC = eaps_pkg::PULSE_WIDTH_CYC
) (
	input  wire logic                       i_clk,   // Core clock
	input  wire logic                       i_rst_n, // Synchronised reset, active low
	input  wire logic                       i_raw,   // Undivided pulse strobe
	input  wire logic [eaps_pkg::CFR_W-1:0] i_num,   // Pulse numerator setting
	input  wire logic [eaps_pkg::CFR_W-1:0] i_den,   // Pulse denominator setting
	output logic                            o_pulse  // Scaled pulse output
);

	eaps_pkg::eaps_pulse_st_t r;
	eaps_pkg::eaps_pulse_st_t r_nxt;

	if (WIDTH_CYC < 1 || 2 * WIDTH_CYC >= (1 << eaps_pkg::WCNT_W)) begin : g_chk
		$error("eaps_pulse: WIDTH_CYC out of range");
	end

	// Rate multiplier: each raw pulse earns num+1 credits, each output costs den+1
	always_comb begin
		logic [eaps_pkg::CRD_W:0] sum;
		logic [eaps_pkg::CRD_W:0] cost;
		sum   = '0;
		cost  = '0;
		r_nxt = r;
		sum   = {1'b0, r.credit} + (i_raw ? (eaps_pkg::CRD_W+1)'(i_num) + 1'b1 : '0); // R13
		cost  = (eaps_pkg::CRD_W+1)'(i_den) + 1'b1; // R13
		// Saturate rather than wrap, so an overrun only loses rate, not sign
		if (sum[eaps_pkg::CRD_W]) begin
			sum = {1'b0, {eaps_pkg::CRD_W{1'b1}}};
		end
		if (r.wcnt != '0) begin
			r_nxt.wcnt = r.wcnt - 1'b1;
		end else if (sum >= cost) begin
			sum        = sum - cost;
			r_nxt.wcnt = eaps_pkg::WCNT_W'(2 * WIDTH_CYC);
		end
		r_nxt.credit = sum[eaps_pkg::CRD_W-1:0];
		// High for the first half of the window, low for the second
		r_nxt.pulse  = (r_nxt.wcnt > eaps_pkg::WCNT_W'(WIDTH_CYC));
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	assign o_pulse = r.pulse;

endmodule // eaps_pulse

// ==== hdl/eaps_top.sv ====
// Operation
// R1: Apparent power word added to hidden accumulator every fourth clock.
// R2: Visible apparent total is 24 bits and wraps; low bits stay hidden.
// R3: Apparent divider zero means divide by one; otherwise fill time scales.
// R4: Line apparent total sums over whole half cycles using zero crossings.
// R5: Line apparent accumulation always runs; there is no enable.
// R6: Line apparent total fed from same scaled path as free total.
// R7: Pulse output reflects active energy only, never apparent energy.
// R8: Half cycle count setting sets interval length, up to 65535.
// R9: Period register counts ticks of eight clocks per line period.
// R10: Active divider scales active totals only, not pulse frequency.
// R11: Active divider resets to zero, no division.
// R12: Active gain scales totals and pulses by one plus gain over 4096.
// R13: Pulse rate times numerator plus one over denominator plus one.
// R14: Numerator and denominator both reset to 0x3F.
// R15: Undivided pulse rate reaches at most 23 kHz at full scale.
// R16: Host reads line active total before line apparent total.
// R17: Half cycle count setting is a 16 bit unsigned value.
// R18: Active gain is signed two's complement, about plus or minus half.
// R19: Interval end latches line totals and restarts without losing samples.
`timescale 1ns/1ps
module eaps_top #(
	parameter longint PULSE_THRESHOLD = eaps_pkg::PULSE_THRESHOLD_DEF,
	parameter int     PULSE_WIDTH     = eaps_pkg::PULSE_WIDTH_CYC
) (
	input  wire logic                              i_clk,              // Core clock, 250 MHz
	input  wire logic                              i_resetn,           // Async reset, active low
	input  wire logic                              i_hsel,             // AHB slave select
	input  wire logic [31:0]                       i_haddr,            // AHB address
	input  wire logic [1:0]                        i_htrans,           // AHB transfer type
	input  wire logic                              i_hwrite,           // AHB write flag
	input  wire logic [2:0]                        i_hsize,            // AHB size
	input  wire logic [31:0]                       i_hwdata,           // AHB write data
	input  wire logic                              i_hready,           // AHB bus ready
	output logic [31:0]                            o_hrdata,           // AHB read data
	output logic                                   o_hreadyout,        // AHB slave ready
	output logic                                   o_hresp,            // AHB response
	input  wire logic signed [eaps_pkg::PWR_W-1:0] i_apparent_power,   // Apparent power word
	input  wire logic signed [eaps_pkg::PWR_W-1:0] i_active_power,     // Active power word
	input  wire logic                              i_zero_cross,       // Half cycle crossing strobe
	output logic                                   o_calibration_pulse_output // Active energy pulse
);

	if (PULSE_THRESHOLD < 1 || PULSE_THRESHOLD >= (64'sd1 <<< (eaps_pkg::PACC_W - 2))) begin : g_chk
		$error("eaps_top: PULSE_THRESHOLD out of range");
	end

	localparam logic signed [eaps_pkg::PACC_W-1:0] THR = eaps_pkg::PACC_W'(PULSE_THRESHOLD);

	// Reset release through two flops; assertion stays asynchronous
	logic [1:0] rst_sync_r;
	logic       rst_n;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_r[1];

	eaps_pkg::eaps_top_st_t r;
	eaps_pkg::eaps_top_st_t r_nxt;

	// Divide by accumulating against div * 2^24; at most one carry per sample
	// since the sample is smaller than the limit, so no iterative divider is needed.
	function automatic eaps_pkg::eaps_div_t div_step(
		input logic signed [eaps_pkg::LOW_W-1:0] low,
		input logic signed [eaps_pkg::PG_W-1:0]  p,
		input logic [eaps_pkg::DIV_W-1:0]        d
	);
		logic [eaps_pkg::DIV_W-1:0]        d_eff;
		logic signed [eaps_pkg::LOW_W-1:0] lim;
		logic signed [eaps_pkg::LOW_W-1:0] sum;
		eaps_pkg::eaps_div_t               res;
		d_eff = (d == '0) ? eaps_pkg::DIV_W'(1) : d; // R3 R11
		lim   = signed'({{(eaps_pkg::LOW_W - eaps_pkg::DIV_W - eaps_pkg::TOT_W){1'b0}},
			d_eff, {eaps_pkg::TOT_W{1'b0}}}); // R2
		sum   = low + eaps_pkg::LOW_W'(p);
		if (sum >= lim) begin
			res.low  = sum - lim;
			res.step = 2'sd1;
		end else if (sum < 0) begin
			res.low  = sum + lim;
			res.step = -2'sd1;
		end else begin
			res.low  = sum;
			res.step = 2'sd0;
		end
		return res;
	endfunction

	// Register read mux over the current or freshly written state
	function automatic logic [31:0] read_reg(
		input eaps_pkg::eaps_top_st_t s,
		input logic [eaps_pkg::IDX_W-1:0] idx
	);
		logic [7:0] ofs;
		ofs = {idx, 2'b00};
		unique case (ofs)
			eaps_pkg::OFS_APP_DIV:   read_reg = 32'(s.app_div);
			eaps_pkg::OFS_ACT_DIV:   read_reg = 32'(s.act_div);
			eaps_pkg::OFS_ACT_GAIN:  read_reg = 32'(s.act_gain);
			eaps_pkg::OFS_PULSE_NUM: read_reg = 32'(s.pulse_num);
			eaps_pkg::OFS_PULSE_DEN: read_reg = 32'(s.pulse_den);
			eaps_pkg::OFS_HALF_SET:  read_reg = 32'(s.half_set);
			eaps_pkg::OFS_APP_TOTAL: read_reg = 32'(s.app_total);
			eaps_pkg::OFS_LINE_APP:  read_reg = 32'(s.line_app);
			eaps_pkg::OFS_ACT_TOTAL: read_reg = 32'(s.act_total);
			eaps_pkg::OFS_LINE_ACT:  read_reg = 32'(s.line_act);
			eaps_pkg::OFS_PERIOD:    read_reg = 32'(s.period);
			default:                 read_reg = 32'h0000_0000;
		endcase
	endfunction

	// Whole next-state computation
	always_comb begin
		logic                                          tick4;
		logic                                          tick8;
		logic signed [eaps_pkg::PWR_W+eaps_pkg::GAIN_W-1:0] prod;
		logic signed [eaps_pkg::PG_W-1:0]              p_app;
		logic signed [eaps_pkg::PG_W-1:0]              p_act;
		eaps_pkg::eaps_div_t                           app_res;
		eaps_pkg::eaps_div_t                           act_res;
		logic [eaps_pkg::TOT_W-1:0]                    app_inc;
		logic [eaps_pkg::TOT_W-1:0]                    act_inc;
		logic [eaps_pkg::HALF_W-1:0]                   half_eff;
		logic [eaps_pkg::HALF_W:0]                     half_next;
		logic                                          addr_ok;
		logic signed [eaps_pkg::PACC_W-1:0]            pacc_sum;
		tick4     = 1'b0;
		tick8     = 1'b0;
		prod      = '0;
		p_app     = '0;
		p_act     = '0;
		app_res   = '0;
		act_res   = '0;
		app_inc   = '0;
		act_inc   = '0;
		half_eff  = '0;
		half_next = '0;
		addr_ok   = 1'b0;
		pacc_sum  = '0;
		r_nxt     = r;

		// Sample and period tick enables from one free counter
		r_nxt.tick_cnt = r.tick_cnt + 3'd1;
		tick4 = (r.tick_cnt[1:0] == 2'(eaps_pkg::ACC_SAMPLE_CYC - 1)); // R1
		tick8 = (r.tick_cnt == 3'(eaps_pkg::PERIOD_TICK_CYC - 1)); // R9

		// Signed gain: p * (1 + g / 2^12); g is two's complement
		prod  = i_active_power * $signed(r.act_gain); // R18
		p_act = eaps_pkg::PG_W'(i_active_power) + eaps_pkg::PG_W'(prod >>> eaps_pkg::FRAC_W); // R12
		p_app = eaps_pkg::PG_W'(i_apparent_power);

		// Energy totals advance on the sample tick only
		if (tick4) begin
			app_res       = div_step(r.app_low, p_app, r.app_div); // R1 R3
			act_res       = div_step(r.act_low, p_act, r.act_div); // R10 R12
			r_nxt.app_low = app_res.low;
			r_nxt.act_low = act_res.low;
		end
		app_inc = eaps_pkg::TOT_W'(app_res.step);
		act_inc = eaps_pkg::TOT_W'(act_res.step);
		r_nxt.app_total = r.app_total + app_inc; // R2
		r_nxt.act_total = r.act_total + act_inc;

		// Undivided pulse path: gained power, no active divider in it
		r_nxt.raw_pulse = 1'b0;
		if (tick4) begin
			pacc_sum = r.pacc + eaps_pkg::PACC_W'(p_act); // R10 R12 R7
			if (pacc_sum >= THR) begin
				pacc_sum        = pacc_sum - THR; // R15
				r_nxt.raw_pulse = 1'b1;
			end else if (pacc_sum <= -THR) begin
				pacc_sum        = pacc_sum + THR; // R15
				r_nxt.raw_pulse = 1'b1;
			end
			r_nxt.pacc = pacc_sum;
		end

		// Line interval: count crossings, latch and restart at the end
		half_eff  = (r.half_set == '0) ? eaps_pkg::HALF_W'(1) : r.half_set; // R8 R17
		half_next = {1'b0, r.half_cnt} + 1'b1;
		r_nxt.line_app_run = r.line_app_run + app_inc; // R5 R6
		r_nxt.line_act_run = r.line_act_run + act_inc;
		if (i_zero_cross) begin
			if (half_next >= {1'b0, half_eff}) begin
				// This cycle's sample goes into the closing interval
				r_nxt.line_app     = r.line_app_run + app_inc; // R4 R19
				r_nxt.line_act     = r.line_act_run + act_inc; // R19
				r_nxt.line_app_run = '0; // R19
				r_nxt.line_act_run = '0;
				r_nxt.half_cnt     = '0;
			end else begin
				r_nxt.half_cnt = half_next[eaps_pkg::HALF_W-1:0]; // R8
			end
		end

		// Period: ticks of eight clocks between every other crossing, saturating
		if (tick8 && r.period_cnt != '1) begin
			r_nxt.period_cnt = r.period_cnt + 1'b1; // R9
		end
		if (i_zero_cross) begin
			r_nxt.zx_phase = ~r.zx_phase;
			if (r.zx_phase) begin
				r_nxt.period     = r.period_cnt; // R9
				r_nxt.period_cnt = '0;
			end
		end

		// AHB data phase: write only whole words to the setting registers
		if (r.dp_valid && r.dp_write) begin
			unique case ({r.dp_idx, 2'b00})
				eaps_pkg::OFS_APP_DIV:  r_nxt.app_div  = i_hwdata[eaps_pkg::DIV_W-1:0];
				eaps_pkg::OFS_ACT_DIV:  r_nxt.act_div  = i_hwdata[eaps_pkg::DIV_W-1:0];
				eaps_pkg::OFS_ACT_GAIN: r_nxt.act_gain = i_hwdata[eaps_pkg::GAIN_W-1:0];
				eaps_pkg::OFS_PULSE_NUM: r_nxt.pulse_num = i_hwdata[eaps_pkg::CFR_W-1:0];
				eaps_pkg::OFS_PULSE_DEN: r_nxt.pulse_den = i_hwdata[eaps_pkg::CFR_W-1:0];
				eaps_pkg::OFS_HALF_SET: r_nxt.half_set = i_hwdata[eaps_pkg::HALF_W-1:0]; // R17
				default:                ;
			endcase
		end

		// AHB address phase; reads sample the post-write state so a read right
		// after a write to the same register already sees the new value
		addr_ok        = i_hsel && i_htrans[1] && i_hready;
		r_nxt.dp_valid = addr_ok && (i_hsize == eaps_pkg::HSIZE_WORD);
		r_nxt.dp_write = i_hwrite;
		r_nxt.dp_idx   = i_haddr[eaps_pkg::IDX_W+1:2];
		if (addr_ok && !i_hwrite) begin
			r_nxt.hrdata = read_reg(r_nxt, i_haddr[eaps_pkg::IDX_W+1:2]);
		end
	end

	// State register with reset values
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			r          <= '0;
			r.app_div  <= eaps_pkg::RST_DIV;
			r.act_div  <= eaps_pkg::RST_DIV; // R11
			r.act_gain <= eaps_pkg::RST_GAIN;
			r.pulse_num <= eaps_pkg::RST_PULSE_NUM; // R14
			r.pulse_den <= eaps_pkg::RST_PULSE_DEN; // R14
			r.half_set <= eaps_pkg::RST_HALF;
		end else begin
			r <= r_nxt;
		end
	end

	// Scaled pulse generation
	eaps_pulse #(
		.WIDTH_CYC (PULSE_WIDTH)
	) u_pulse (
		.i_clk   (i_clk),
		.i_rst_n (rst_n),
		.i_raw   (r.raw_pulse),
		.i_num   (r.pulse_num),
		.i_den   (r.pulse_den),
		.o_pulse (o_calibration_pulse_output)
	);

	// Zero wait state, always OKAY
	assign o_hrdata    = r.hrdata;
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

endmodule // eaps_top

// ==== dv/eaps_host_model.sv ====
`timescale 1ns/1ps
module eaps_host_model (
	input  wire logic i_clk,   // Core clock
	input  wire logic i_pulse, // Meter pulse pin
	output int        o_count  // Pulses seen so far
);
	logic prev_r;

	// Host counts rising edges only, as a pulse counter input would
	always @(posedge i_clk) begin
		prev_r <= i_pulse;
		if (i_pulse && !prev_r)
			o_count <= o_count + 1;
	end

	initial o_count = 0;
endmodule // eaps_host_model

// ==== dv/eaps_top_asserts.sv ====
`timescale 1ns/1ps
module eaps_top_asserts #(
	parameter longint PULSE_THRESHOLD = 64'h0000_0000_0000_03E8,
	parameter int     PULSE_WIDTH     = 4
) (
	input wire logic                              i_clk,          // Clock
	input wire logic                              i_resetn,       // Reset, active low
	input wire logic                              i_hsel,         // Select
	input wire logic [31:0]                       i_haddr,        // Address
	input wire logic [1:0]                        i_htrans,       // Transfer type
	input wire logic                              i_hwrite,       // Write flag
	input wire logic [2:0]                        i_hsize,        // Size
	input wire logic [31:0]                       i_hwdata,       // Write data
	input wire logic                              i_hready,       // Bus ready
	input wire logic [31:0]                       o_hrdata,       // Read data
	input wire logic                              o_hreadyout,    // Slave ready
	input wire logic                              o_hresp,        // Response
	input wire logic signed [eaps_pkg::PWR_W-1:0] i_apparent_power, // Apparent word
	input wire logic signed [eaps_pkg::PWR_W-1:0] i_active_power,   // Active word
	input wire logic                              i_zero_cross,   // Crossing strobe
	input wire logic                              o_calibration_pulse_output // Pulse pin
);
	localparam logic [31:0] MSK [6] = '{32'h0000_00FF, 32'h0000_00FF, 32'h0000_0FFF,
		32'h0000_0FFF, 32'h0000_0FFF, 32'h0000_FFFF};
	logic        dv, dw, seen, zxs;
	logic [5:0]  di;
	logic [31:0] sh [6];
	logic [31:0] last;
	logic [15:0] hi_c, lo_c, zr;

	// Data phase tracking and shadow of writable settings
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			dv   <= 1'b0;
			dw   <= 1'b0;
			di   <= 6'h0;
			sh   <= '{32'h0, 32'h0, 32'h0, 32'h0000_003F, 32'h0000_003F, 32'h0000_0001};
			seen <= 1'b0;
			zxs  <= 1'b0;
			last <= 32'h0;
			hi_c <= 16'h0;
			lo_c <= 16'(PULSE_WIDTH);
			zr   <= 16'hFFFF;
		end else begin
			dv <= i_hsel && i_htrans[1] && i_hready;
			dw <= i_hwrite && (i_hsize == eaps_pkg::HSIZE_WORD);
			di <= i_haddr[7:2];
			if (dv && dw && di < 6'd6)
				sh[di] <= i_hwdata & MSK[di];
			hi_c <= o_calibration_pulse_output ? hi_c + 16'h1 : 16'h0;
			lo_c <= o_calibration_pulse_output ? 16'h0 : ((lo_c == 16'hFFFF) ? lo_c : lo_c + 16'h1);
			zr   <= (i_active_power != 0) ? 16'h0 : ((zr == 16'hFFFF) ? zr : zr + 16'h1);
			// A crossing may relatch the line totals, so forget the last read
			if (i_zero_cross)
				zxs <= 1'b1;
			else if (dv && !dw && di == 6'd7)
				zxs <= 1'b0;
			if (dv && !dw && di == 6'd7) begin
				seen <= 1'b1;
				last <= o_hrdata;
			end
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	property p_bus; o_hreadyout && !o_hresp; endproperty
	a_bus: assert property (p_bus) else $error("Slave stalled or answered with error");
	property p_shadow; dv && !dw && di < 6'd6 |-> o_hrdata == sh[di]; endproperty
	a_shadow: assert property (p_shadow) else $error("Setting read back wrong");
	property p_tot_w; dv && !dw && di >= 6'd6 && di <= 6'd9 |-> o_hrdata[31:24] == 8'h00; endproperty
	a_tot_w: assert property (p_tot_w) else $error("Total wider than 24 bits");
	property p_per_w; dv && !dw && di == 6'd10 |-> o_hrdata[31:16] == 16'h0; endproperty
	a_per_w: assert property (p_per_w) else $error("Period wider than 16 bits");
	property p_pw_hi; $fell(o_calibration_pulse_output) |-> hi_c == PULSE_WIDTH; endproperty
	a_pw_hi: assert property (p_pw_hi) else $error("Pulse high time wrong");
	property p_pw_lo; $rose(o_calibration_pulse_output) |-> lo_c >= PULSE_WIDTH; endproperty
	a_pw_lo: assert property (p_pw_lo) else $error("Pulse low time too short");
	property p_cause; $rose(o_calibration_pulse_output) |-> zr < 2 * PULSE_WIDTH + 32; endproperty
	a_cause: assert property (p_cause) else $error("Pulse without active power");
	property p_line; dv && !dw && di == 6'd7 && seen && !zxs |-> o_hrdata == last; endproperty
	a_line: assert property (p_line) else $error("Line total moved between crossings");
endmodule // eaps_top_asserts

bind eaps_top eaps_top_asserts #(.PULSE_THRESHOLD(PULSE_THRESHOLD), .PULSE_WIDTH(PULSE_WIDTH)) chk_u (
	.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
	.i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
	.o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
	.i_apparent_power(i_apparent_power), .i_active_power(i_active_power),
	.i_zero_cross(i_zero_cross), .o_calibration_pulse_output(o_calibration_pulse_output));

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	localparam logic [23:0] P = 24'h40_0000;
	logic                              clk, rst_n, hsel, hwrite, zx, hready, hresp, pulse;
	logic [1:0]                        htrans;
	logic [2:0]                        hsize;
	logic [31:0]                       haddr, hwdata, hrdata, v, l0, l1;
	logic signed [eaps_pkg::PWR_W-1:0] app, act;
	int                                error_cnt, total_checks, pcount, p0;

	eaps_top #(.PULSE_THRESHOLD(64'h0000_0000_0200_0000), .PULSE_WIDTH(4)) dut_u (
		.i_clk(clk), .i_resetn(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_apparent_power(app),
		.i_active_power(act), .i_zero_cross(zx), .o_calibration_pulse_output(pulse));
	eaps_host_model host_u (.i_clk(clk), .i_pulse(pulse), .o_count(pcount));

	// Free running clock, 4 ns period
	always #2 clk = ~clk;

	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One single word transfer; hold each phase until ready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h0, a};
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= wd;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, v);
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, v);
		check(nm, v, e);
	endtask

	// Power held for exactly n edges, then a settle gap
	task automatic pw(input int n, input logic [23:0] pa, input logic [23:0] pc);
		app <= pa;
		act <= pc;
		repeat (n) @(posedge clk);
		app <= '0;
		act <= '0;
		repeat (12) @(posedge clk);
	endtask

	task automatic zxs(input int n, input int gap);
		repeat (n) begin
			zx <= 1'b1;
			@(posedge clk);
			zx <= 1'b0;
			repeat (gap - 1) @(posedge clk);
		end
	endtask

	task automatic t_regs;
		rd_chk("act_div", eaps_pkg::OFS_ACT_DIV, 32'h0);
		rd_chk("app_div", eaps_pkg::OFS_APP_DIV, 32'h0);
		rd_chk("pulse_num", eaps_pkg::OFS_PULSE_NUM, 32'h3F);
		rd_chk("pulse_den", eaps_pkg::OFS_PULSE_DEN, 32'h3F);
		wr(eaps_pkg::OFS_HALF_SET, 32'hFFFF_FFFF);
		rd_chk("half_set", eaps_pkg::OFS_HALF_SET, 32'h0000_FFFF);
		wr(8'h40, 32'h1234_5678);
		rd_chk("unmapped", 8'h40, 32'h0);
		wr(eaps_pkg::OFS_APP_TOTAL, 32'h00AB_CDEF);
		rd_chk("app_total", eaps_pkg::OFS_APP_TOTAL, 32'h0);
	endtask

	// Three half cycles per interval; one window straddles an interval end
	task automatic t_line;
		wr(eaps_pkg::OFS_HALF_SET, 32'h3);
		zxs(1, 8);
		pw(64, P, P);
		zxs(1, 8);
		rd_chk("line_app", eaps_pkg::OFS_LINE_APP, 32'h0);
		zxs(1, 8);
		rd_chk("line_act", eaps_pkg::OFS_LINE_ACT, 32'h4);
		rd_chk("line_app", eaps_pkg::OFS_LINE_APP, 32'h4);
		rd_chk("app_total", eaps_pkg::OFS_APP_TOTAL, 32'h4);
		rd_chk("line_app", eaps_pkg::OFS_LINE_APP, 32'h4);
		zxs(2, 8);
		app <= P;
		act <= P;
		repeat (30) @(posedge clk);
		zxs(1, 2);
		pw(32, P, P);
		xfer(1'b0, eaps_pkg::OFS_LINE_APP, 32'h0, l0);
		zxs(3, 8);
		xfer(1'b0, eaps_pkg::OFS_LINE_APP, 32'h0, l1);
		check("line_sum", l0 + l1, 32'h4);
		rd_chk("act_total", eaps_pkg::OFS_ACT_TOTAL, 32'h8);
	endtask

	task automatic t_gain;
		wr(eaps_pkg::OFS_APP_DIV, 32'h2);
		wr(eaps_pkg::OFS_ACT_GAIN, 32'h400);
		pw(64, P, P);
		rd_chk("act_total", eaps_pkg::OFS_ACT_TOTAL, 32'hD);
		rd_chk("app_total", eaps_pkg::OFS_APP_TOTAL, 32'hA);
		wr(eaps_pkg::OFS_ACT_GAIN, 32'hC00);
		pw(64, P, P);
		rd_chk("act_total", eaps_pkg::OFS_ACT_TOTAL, 32'h10);
		rd_chk("app_total", eaps_pkg::OFS_APP_TOTAL, 32'hC);
		wr(eaps_pkg::OFS_ACT_GAIN, 32'h0);
	endtask

	task automatic t_pulse;
		repeat (64) @(posedge clk);
		p0 = pcount;
		pw(256, P, 24'h0);
		check("app_pulses", 32'(pcount - p0), 32'h0);
		p0 = pcount;
		pw(256, 24'h0, P);
		repeat (40) @(posedge clk);
		check("pulses", 32'(pcount - p0), 32'h8);
		// Default threshold must keep full scale at 62.5 MS/s under the ceiling
		check("pulse_ceiling", 32'(eaps_pkg::ACT_FULL_SCALE * 64'd62_500_000 <=
			eaps_pkg::PULSE_THRESHOLD_DEF * 64'd23_000), 32'h1);
		wr(eaps_pkg::OFS_ACT_DIV, 32'h5);
		wr(eaps_pkg::OFS_PULSE_NUM, 32'h0);
		wr(eaps_pkg::OFS_PULSE_DEN, 32'h1);
		p0 = pcount;
		pw(256, 24'h0, P);
		repeat (40) @(posedge clk);
		check("pulses", 32'(pcount - p0), 32'h4);
		rd_chk("act_total", eaps_pkg::OFS_ACT_TOTAL, 32'h23);
	endtask

	// Crossings 400 clocks apart make a line period of 100 ticks
	task automatic t_period;
		zxs(5, 400);
		xfer(1'b0, eaps_pkg::OFS_PERIOD, 32'h0, l0);
		check("period", {31'h0, l0 >= 32'd99 && l0 <= 32'd101}, 32'h1);
	endtask

	task automatic wrap_up;
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{hsel, hwrite, zx} = 3'b000;
		htrans = 2'b00;
		hsize = eaps_pkg::HSIZE_WORD;
		haddr = 32'h0;
		hwdata = 32'h0;
		app = '0;
		act = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_line();
		t_gain();
		t_pulse();
		t_period();
		wrap_up();
	end

	// Watchdog far beyond the expected run of a few thousand cycles
	initial begin
		#200000;
		error_cnt++;
		wrap_up();
	end
endmodule // tb_top
